// [logic/smc_sleep_ctrl.sv]
/*
 * Sleep mode controller: control register, sleep entry, domain gating,
 * wake filtering, start-up wait, post-wake halt and power-off handling.
 * Assumes the CPU core pulses sleep_instr when it executes a sleep
 * instruction and writes the control register through ctrl_wr.
 */
`timescale 1ns/1ns
`include "smc_consts.svh"

module smc_sleep_ctrl #(
    parameter int STARTUP_CYC = `SMC_STARTUP_CYC,
    parameter int HALT_CYC = `SMC_WAKE_HALT_CYC,
    parameter int OFF_WINDOW_CYC = `SMC_OFF_WINDOW_CYC
) (
    input wire logic clk_sys, // System clock, 250 MHz.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic ctrl_wr, // Control register write strobe.
    input smc_pkg::smc_ctrl_t ctrl_wdata, // Control register write data.
    output smc_pkg::smc_ctrl_t ctrl_rdata, // Control register contents.
    input wire logic sleep_instr, // Sleep instruction executed.
    input smc_pkg::smc_wake_t wake_req, // Enabled wake requests.
    input wire logic discharge_fet_on, // Discharge FET is conducting.
    input wire logic short_prot_cfg, // Short-circuit protection enabled by software.
    output smc_pkg::smc_gates_t gates, // Clock, oscillator and power enables.
    output logic short_prot_en, // Short-circuit protection running.
    output logic cpu_stall, // CPU must not execute.
    output logic wake_irq, // Pulse: run the wake interrupt handler.
    output logic reset_req, // Pulse: full reset on return from power-off.
    output logic retain_ok, // Register file and SRAM contents valid.
    output smc_pkg::smc_state_t state // Sequencer state.
);
    import smc_pkg::*;

    localparam int TW = `SMC_TMR_W;
    localparam logic [TW-1:0] START_LOAD = TW'(STARTUP_CYC - 1);
    localparam logic [TW-1:0] HALT_LOAD = TW'(HALT_CYC - 1);
    localparam logic [2:0] WIN_LOAD = 3'(OFF_WINDOW_CYC);

    // ------------------------------------------------------------------------
    // Registers and internal signals
    // ------------------------------------------------------------------------
    smc_ctrl_t ctrl_ff;
    smc_state_t state_ff, nxt_state;
    smc_mode_t mode_ff, nxt_mode;
    smc_gates_t gates_ff;
    logic [2:0] win_ff;
    logic stall_ff;
    logic irq_ff;
    logic rst_req_ff;
    logic retain_ff;
    logic short_ff;
    logic wake_hit;
    logic tmr_load;
    logic [TW-1:0] tmr_val;
    logic tmr_done;
    logic sleep_ok;
    logic win_open;

    // ------------------------------------------------------------------------
    // Domain enables for a given state and mode
    // ------------------------------------------------------------------------
    // While halted after wake the active clocks already run; only the stall
    // holds the CPU, so the handler starts the cycle the halt ends.
    function automatic smc_gates_t gates_for(input smc_state_t s, input smc_mode_t m);
        smc_gates_t g;
        g = '0;
        g.cpu_power = 1'b1;
        g.ultra_low_power_osc = 1'b1;
        g.watchdog_timer = 1'b1;
        g.protection = 1'b1;
        g.external_irq = 1'b1;
        case (s)
            ST_ACTIVE, ST_HALT: begin
                g.cpu_clock = 1'b1;
                g.flash_clock = 1'b1;
                g.io_clock = 1'b1;
                g.fast_rc_osc = 1'b1;
                g.async_osc = 1'b1;
                g.smbus_full = 1'b1;
                g.voltage_adc = 1'b1;
                g.charge_counter_converter = 1'b1;
                g.wakeup_timer = 1'b1;
            end
            ST_START: begin
                // Oscillators restart and settle before any clock is released.
                g.fast_rc_osc = 1'b1;
                g.async_osc = 1'b1;
                g.smbus_wake_only = 1'b1;
                g.charge_counter_converter = (m == SMC_PSAVE);
                g.wakeup_timer = (m == SMC_PSAVE);
            end
            ST_SLEEP: begin
                case (m)
                    SMC_IDLE: begin
                        g.io_clock = 1'b1;
                        g.fast_rc_osc = 1'b1;
                        g.async_osc = 1'b1;
                        g.smbus_full = 1'b1;
                        g.voltage_adc = 1'b1;
                        g.charge_counter_converter = 1'b1;
                        g.wakeup_timer = 1'b1;
                    end
                    SMC_QUIET: begin
                        g.fast_rc_osc = 1'b1;
                        g.async_osc = 1'b1;
                        g.smbus_wake_only = 1'b1;
                        g.voltage_adc = 1'b1;
                        g.charge_counter_converter = 1'b1;
                        g.wakeup_timer = 1'b1;
                    end
                    SMC_PSAVE: begin
                        g.async_osc = 1'b1;
                        g.smbus_wake_only = 1'b1;
                        g.charge_counter_converter = 1'b1;
                        g.wakeup_timer = 1'b1;
                    end
                    SMC_PDOWN: begin
                        g.smbus_wake_only = 1'b1;
                    end
                    default: begin
                        g = '0;
                    end
                endcase
            end
            ST_OFF: begin
                g = '0;
                g.charger_detector = 1'b1;
            end
            default: begin
                g = '0;
            end
        endcase
        return g;
    endfunction

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    smc_wake_select u_wake (
        .mode(mode_ff),
        .req(wake_req),
        .hit(wake_hit)
    );

    smc_cycle_timer #(.W(TW)) u_tmr (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .load(tmr_load),
        .load_val(tmr_val),
        .expired(tmr_done)
    );

    // Power-off is reachable only inside the window after the arming write.
    assign win_open = (win_ff != 3'h0);
    // Reserved codes are ignored: the instruction then behaves as a no-op.
    assign sleep_ok = sleep_instr && ctrl_ff.sleep_enable
        && (ctrl_ff.mode <= `SMC_MODE_POFF)
        && ((ctrl_ff.mode != `SMC_MODE_POFF) || win_open);

    // ------------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_mode = mode_ff;
        tmr_load = 1'b0;
        tmr_val = HALT_LOAD;
        case (state_ff)
            ST_ACTIVE: begin
                if (sleep_ok) begin
                    nxt_mode = smc_mode_t'(ctrl_ff.mode);
                    nxt_state = (ctrl_ff.mode == `SMC_MODE_POFF) ? ST_OFF : ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_hit) begin
                    tmr_load = 1'b1;
                    if (mode_ff == SMC_PSAVE || mode_ff == SMC_PDOWN) begin
                        tmr_val = START_LOAD;
                        nxt_state = ST_START;
                    end else begin
                        nxt_state = ST_HALT;
                    end
                end
            end
            ST_START: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    nxt_state = ST_HALT;
                end
            end
            ST_HALT: begin
                if (tmr_done) begin
                    nxt_state = ST_ACTIVE;
                end
            end
            ST_OFF: begin
                if (wake_req.charger_connect) begin
                    nxt_state = ST_ACTIVE;
                end
            end
            default: begin
                nxt_state = ST_ACTIVE;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Sequencer state and output registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_ACTIVE;
            mode_ff <= SMC_IDLE;
        end else begin
            state_ff <= nxt_state;
            mode_ff <= nxt_mode;
        end
    end

    // Enables are registered from the next state so they change with it.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            gates_ff <= gates_for(ST_ACTIVE, SMC_IDLE);
            stall_ff <= 1'b0;
        end else begin
            gates_ff <= gates_for(nxt_state, nxt_mode);
            stall_ff <= (nxt_state != ST_ACTIVE);
        end
    end

    // Handler request as the halt ends; reset request as power returns.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_ff <= 1'b0;
            rst_req_ff <= 1'b0;
        end else begin
            irq_ff <= (state_ff == ST_HALT) && tmr_done;
            rst_req_ff <= (state_ff == ST_OFF) && wake_req.charger_connect;
        end
    end

    // Contents are lost once CPU power is removed and stay invalid until
    // the reset that follows power-off has been issued.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            retain_ff <= 1'b1;
        end else if (nxt_state == ST_OFF) begin
            retain_ff <= 1'b0;
        end else if (rst_req_ff) begin
            retain_ff <= 1'b1;
        end
    end

    // Short-circuit sensing follows the discharge FET to save current.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            short_ff <= 1'b0;
        end else begin
            short_ff <= short_prot_cfg && discharge_fet_on && nxt_state != ST_OFF;
        end
    end

    // ------------------------------------------------------------------------
    // Control register and power-off window
    // ------------------------------------------------------------------------
    // A software write in the cycle the window closes wins over the
    // auto-clear, so the fresh value is never lost.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff <= `SMC_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_ff <= ctrl_wdata;
        end else if (rst_req_ff) begin
            ctrl_ff <= `SMC_CTRL_RESET;
        end else if (win_ff == 3'h1) begin
            ctrl_ff <= `SMC_CTRL_RESET;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            win_ff <= 3'h0;
        end else if (ctrl_wr && ctrl_wdata.sleep_enable
                     && ctrl_wdata.mode == `SMC_MODE_POFF) begin
            win_ff <= WIN_LOAD;
        end else if (win_ff != 3'h0) begin
            win_ff <= win_ff - 3'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign ctrl_rdata = ctrl_ff;
    assign gates = gates_ff;
    assign short_prot_en = short_ff;
    assign cpu_stall = stall_ff;
    assign wake_irq = irq_ff;
    assign reset_req = rst_req_ff;
    assign retain_ok = retain_ff;
    assign state = state_ff;
endmodule // smc_sleep_ctrl

// [logic/smc_consts.svh]
/*
 * Constants of the sleep mode controller: control bit positions, mode codes,
 * reset values, wake-source masks and timing counts.
 * Assumes a 250 MHz system clock; included by the package and every design module.
 */
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Control register layout
// ----------------------------------------------------------------------------
`define SMC_CTRL_W 4
`define SMC_CTRL_SE_BIT 0
`define SMC_CTRL_MODE_LSB 1
`define SMC_CTRL_MODE_MSB 3
`define SMC_CTRL_RESET 4'h0

// ----------------------------------------------------------------------------
// Sleep mode codes
// ----------------------------------------------------------------------------
`define SMC_MODE_IDLE 3'h0
`define SMC_MODE_QUIET 3'h1
`define SMC_MODE_PDOWN 3'h2
`define SMC_MODE_PSAVE 3'h3
`define SMC_MODE_POFF 3'h4

// ----------------------------------------------------------------------------
// Wake-source masks, one bit per field of the wake struct
// ----------------------------------------------------------------------------
`define SMC_WAKE_W 11
`define SMC_MASK_IDLE 11'h3FF
`define SMC_MASK_QUIET 11'h1FF
`define SMC_MASK_PSAVE 11'h0BF
`define SMC_MASK_PDOWN 11'h01E
`define SMC_MASK_POFF 11'h400
`define SMC_MASK_NONE 11'h000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SMC_CLK_PERIOD_NS 4
`define SMC_STARTUP_NS 1000
`define SMC_STARTUP_CYC ((`SMC_STARTUP_NS + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS)
`define SMC_WAKE_HALT_CYC 4
`define SMC_OFF_WINDOW_CYC 4
`define SMC_TMR_W 12

`endif

// [logic/smc_pkg.sv]
/*
 * Types of the sleep mode controller: modes, states and signal bundles.
 * Assumes smc_consts.svh is on the include path.
 */
`include "smc_consts.svh"

package smc_pkg;

    // ------------------------------------------------------------------------
    // Mode and state encodings
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        SMC_IDLE = `SMC_MODE_IDLE,
        SMC_QUIET = `SMC_MODE_QUIET,
        SMC_PDOWN = `SMC_MODE_PDOWN,
        SMC_PSAVE = `SMC_MODE_PSAVE,
        SMC_POFF = `SMC_MODE_POFF
    } smc_mode_t;

    typedef enum logic [5:0] {
        ST_ACTIVE = 6'h01,
        ST_SLEEP = 6'h02,
        ST_START = 6'h04,
        ST_HALT = 6'h08,
        ST_OFF = 6'h10,
        ST_SPARE = 6'h20
    } smc_state_t;

    // ------------------------------------------------------------------------
    // Bundles: wake requests (MSB first), domain enables and control register
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic charger_connect;
        logic other_io;
        logic vadc_done;
        logic charge_counter_converter;
        logic store_ready;
        logic wakeup_timer;
        logic watchdog_timer;
        logic smbus_match;
        logic external_irq;
        logic protection;
        logic regular_current_wakeup;
    } smc_wake_t;

    typedef struct packed {
        logic cpu_clock;
        logic flash_clock;
        logic io_clock;
        logic fast_rc_osc;
        logic async_osc;
        logic ultra_low_power_osc;
        logic smbus_full;
        logic smbus_wake_only;
        logic voltage_adc;
        logic charge_counter_converter;
        logic wakeup_timer;
        logic watchdog_timer;
        logic protection;
        logic external_irq;
        logic cpu_power;
        logic charger_detector;
    } smc_gates_t;

    typedef struct packed {
        logic [2:0] mode;
        logic sleep_enable;
    } smc_ctrl_t;

endpackage

// [logic/smc_cycle_timer.sv]
/*
 * Down counter shared by the start-up wait and the post-wake halt.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ns
`include "smc_consts.svh"

module smc_cycle_timer #(
    parameter int W = `SMC_TMR_W
) (
    input wire logic clk_sys, // System clock.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic load, // Load pulse.
    input wire logic [W-1:0] load_val, // Cycles minus one.
    output logic expired // High while the count is zero.
);
    logic [W-1:0] cnt_ff;

    // Loading wins over counting so a back-to-back reload is never lost.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= '0;
        end else if (load) begin
            cnt_ff <= load_val;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - W'(1);
        end
    end

    assign expired = (cnt_ff == '0);
endmodule // smc_cycle_timer

// [logic/smc_wake_select.sv]
/*
 * Filters the wake requests through the set that a sleep mode accepts.
 * Assumes requests are already gated by their own interrupt enables.
 */
`timescale 1ns/1ns
`include "smc_consts.svh"

module smc_wake_select (
    input smc_pkg::smc_mode_t mode, // Mode being slept in.
    input smc_pkg::smc_wake_t req, // Raw wake requests.
    output logic hit // Some accepted source is requesting.
);
    import smc_pkg::*;

    // Mode to accepted-source mask; unknown codes accept nothing.
    function automatic logic [`SMC_WAKE_W-1:0] mask_of(input smc_mode_t m);
        case (m)
            SMC_IDLE: mask_of = `SMC_MASK_IDLE;
            SMC_QUIET: mask_of = `SMC_MASK_QUIET;
            SMC_PSAVE: mask_of = `SMC_MASK_PSAVE;
            SMC_PDOWN: mask_of = `SMC_MASK_PDOWN;
            SMC_POFF: mask_of = `SMC_MASK_POFF;
            default: mask_of = `SMC_MASK_NONE;
        endcase
    endfunction

    assign hit = |(mask_of(mode) & req);
endmodule // smc_wake_select

// [bench/smc_sleep_checker.sv]
/* Checker: timing relations on the sleep controller ports.
   Assumes it is bound to smc_sleep_ctrl and sees only its ports. */
`timescale 1ns/1ns
module smc_sleep_checker #(
    parameter int STARTUP_CYC = 3
) (
    input wire logic clk_sys, // Clock.
    input wire logic rstn, // Reset, low.
    input wire logic ctrl_wr, // Write.
    input smc_pkg::smc_ctrl_t ctrl_wdata, // Data.
    input smc_pkg::smc_ctrl_t ctrl_rdata, // Register.
    input wire logic sleep_instr, // Sleep.
    input smc_pkg::smc_wake_t wake_req, // Wake.
    input wire logic discharge_fet_on, // FET.
    input smc_pkg::smc_gates_t gates, // Enables.
    input wire logic short_prot_en, // Shorts.
    input wire logic wake_irq, // Handler.
    input wire logic reset_req, // Reset out.
    input wire logic retain_ok, // Memory.
    input smc_pkg::smc_state_t state // State.
);
    import smc_pkg::*;
    // ------------------------------------------------------------------
    // Start-up length counter
    // ------------------------------------------------------------------
    logic [11:0] start_cnt_ff;
    logic [11:0] nxt_start_cnt;
    logic go;
    // A counter, not a repetition, since the wait is a parameter.
    assign nxt_start_cnt = (state == ST_START) ? start_cnt_ff + 12'h001 : 12'h000;
    assign go = state == ST_ACTIVE && sleep_instr && ctrl_rdata.sleep_enable;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            start_cnt_ff <= 12'h000;
        end else begin
            start_cnt_ff <= nxt_start_cnt;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_se_gate: assert property (state == ST_ACTIVE && sleep_instr &&
        !ctrl_rdata.sleep_enable |=> state == ST_ACTIVE) else $error("slept without enable");
    chk_idle_gates: assert property (go && ctrl_rdata.mode == SMC_IDLE |=>
        state == ST_SLEEP && !gates.cpu_clock && !gates.flash_clock && gates.io_clock)
        else $error("idle gating wrong");
    chk_down_gates: assert property (go && ctrl_rdata.mode == SMC_PDOWN |=>
        !gates.fast_rc_osc && !gates.async_osc && gates.ultra_low_power_osc)
        else $error("power-down gating wrong");
    chk_start_len: assert property ($fell(state == ST_START) |->
        state == ST_HALT && start_cnt_ff == STARTUP_CYC) else $error("start-up length wrong");
    chk_halt_len: assert property ($rose(state == ST_HALT) |-> (state == ST_HALT)[*4]
        ##1 (state == ST_ACTIVE && wake_irq)) else $error("halt length wrong");
    chk_down_mask: assert property (state == ST_SLEEP && ctrl_rdata.mode == SMC_PDOWN &&
        (wake_req & 11'h01E) == 11'h000 |=> state == ST_SLEEP) else $error("bad wake source");
    chk_auto_clear: assert property (ctrl_wr && ctrl_wdata == 4'h9 ##1
        (!ctrl_wr && state == ST_ACTIVE)[*4] |=> ctrl_rdata == 4'h0) else $error("no auto-clear");
    chk_off_gates: assert property (state == ST_OFF |->
        gates == 16'h0001 && !retain_ok) else $error("power-off gating wrong");
    chk_off_return: assert property (state == ST_OFF && wake_req.charger_connect |=>
        state == ST_ACTIVE && reset_req) else $error("no reset on return");
    chk_short_off: assert property (!$past(discharge_fet_on) |->
        !short_prot_en) else $error("short protection on with FET off");
endmodule // smc_sleep_checker

bind smc_sleep_ctrl smc_sleep_checker #(.STARTUP_CYC(STARTUP_CYC)) chk_u (
    .clk_sys(clk_sys), .rstn(rstn), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .ctrl_rdata(ctrl_rdata), .sleep_instr(sleep_instr), .wake_req(wake_req),
    .discharge_fet_on(discharge_fet_on), .gates(gates), .short_prot_en(short_prot_en),
    .wake_irq(wake_irq), .reset_req(reset_req), .retain_ok(retain_ok), .state(state)
);

// [bench/smc_cpu_model.sv]
/* CPU core model: control writes and sleep instructions.
   Assumes the bench calls its tasks; all changes land on falling edges. */
`timescale 1ns/1ns
module smc_cpu_model (
    input wire logic clk_sys, // Clock.
    output logic ctrl_wr, // Write strobe.
    output smc_pkg::smc_ctrl_t ctrl_wdata, // Write data.
    output logic sleep_instr // Sleep pulse.
);
    import smc_pkg::*;
    // ------------------------------------------------------------------
    // Core requests
    // ------------------------------------------------------------------
    // Quiet at time zero: no write and no sleep pulse.
    initial begin
        ctrl_wr = 1'b0;
        ctrl_wdata = 4'h0;
        sleep_instr = 1'b0;
    end
    // Data is inverted after the strobe so a stale value never looks valid.
    task automatic write_ctrl(input logic [2:0] mode, input logic se);
        @(negedge clk_sys);
        ctrl_wr = 1'b1;
        ctrl_wdata = {mode, se};
        @(negedge clk_sys);
        ctrl_wr = 1'b0;
        ctrl_wdata = ~ctrl_wdata;
    endtask
    // Sleep after gap cycles; gaps 0..3 after a write stay in the window.
    task automatic do_sleep(input int gap);
        repeat (gap) @(negedge clk_sys);
        sleep_instr = 1'b1;
        @(negedge clk_sys);
        sleep_instr = 1'b0;
    endtask
endmodule // smc_cpu_model

// [bench/testbench.sv]
/* Testbench of the sleep mode controller, one task per scenario.
   Assumes the CPU model and the bound checker are compiled alongside. */
`timescale 1ns/1ns
module testbench;
    import smc_pkg::*;
    localparam int STARTUP = 3;
    logic clk_sys;
    logic rstn;
    logic ctrl_wr, sleep_instr, discharge_fet_on, short_prot_cfg;
    logic short_prot_en, cpu_stall, wake_irq, reset_req, retain_ok;
    smc_ctrl_t ctrl_wdata, ctrl_rdata;
    smc_wake_t wake_req;
    smc_gates_t gates;
    smc_state_t state;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    // ------------------------------------------------------------------
    // Clock, instances and shared tasks
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // A short start-up keeps the run brief; expectations use the same value.
    smc_sleep_ctrl #(.STARTUP_CYC(STARTUP)) dut_u (
        .clk_sys(clk_sys), .rstn(rstn), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .ctrl_rdata(ctrl_rdata), .sleep_instr(sleep_instr), .wake_req(wake_req),
        .discharge_fet_on(discharge_fet_on), .short_prot_cfg(short_prot_cfg),
        .gates(gates), .short_prot_en(short_prot_en), .cpu_stall(cpu_stall),
        .wake_irq(wake_irq), .reset_req(reset_req), .retain_ok(retain_ok), .state(state));
    smc_cpu_model cpu_u (.clk_sys(clk_sys), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .sleep_instr(sleep_instr));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Cuts a hang short; the tests need about a hundred cycles.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            finish_test();
        end
    end
    // Raises a wake level and times the return to active.
    task automatic wake_time(input logic [10:0] src, input int exp_n);
        int n;
        n = 0;
        wake_req = src;
        while (state !== ST_ACTIVE && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        wake_req = 11'h000;
        check(16'(n), 16'(exp_n));
        check(16'({wake_irq, cpu_stall}), 16'h0002);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_refused();
        check(16'({ctrl_rdata, state, retain_ok}), 16'({4'h0, ST_ACTIVE, 1'b1}));
        check(16'(gates), 16'hFEFE);
        cpu_u.write_ctrl(SMC_IDLE, 1'b0);
        cpu_u.do_sleep(0);
        check(16'({state, cpu_stall}), 16'({ST_ACTIVE, 1'b0}));
        cpu_u.write_ctrl(3'h5, 1'b1);
        cpu_u.do_sleep(0);
        check(16'(state), 16'(ST_ACTIVE));
    endtask
    // Each mode: a refused source first, then an accepted one.
    task automatic t_modes();
        smc_mode_t mode_tab [4] = '{SMC_IDLE, SMC_QUIET, SMC_PSAVE, SMC_PDOWN};
        logic [10:0] bad_tab [4] = '{11'h400, 11'h600, 11'h740, 11'h7E1};
        logic [10:0] good_tab [4] = '{11'h200, 11'h100, 11'h020, 11'h008};
        for (int i = 0; i < 4; i++) begin
            cpu_u.write_ctrl(mode_tab[i], 1'b1);
            cpu_u.do_sleep(0);
            check(16'({state, gates.cpu_clock}), 16'({ST_SLEEP, 1'b0}));
            check(16'({gates.fast_rc_osc, gates.io_clock}), 16'({i < 2, i == 0}));
            check(16'({gates.smbus_full, gates.smbus_wake_only}), 16'({i == 0, i != 0}));
            wake_req = bad_tab[i];
            repeat (4) @(negedge clk_sys);
            check(16'(state), 16'(ST_SLEEP));
            wake_time(good_tab[i], i < 2 ? 5 : 5 + STARTUP);
            cpu_u.write_ctrl(mode_tab[i], 1'b0);
        end
    endtask
    // Power-off entered on the last window cycle, left by charger connect.
    task automatic t_poff();
        cpu_u.write_ctrl(SMC_POFF, 1'b1);
        check(16'(ctrl_rdata), 16'h0009);
        cpu_u.do_sleep(3);
        check(16'({state, retain_ok}), 16'({ST_OFF, 1'b0}));
        check(16'(gates), 16'h0001);
        wake_req = 11'h3FF;
        repeat (3) @(negedge clk_sys);
        check(16'(state), 16'(ST_OFF));
        wake_req = 11'h400;
        @(negedge clk_sys);
        wake_req = 11'h000;
        check(16'({state, reset_req}), 16'({ST_ACTIVE, 1'b1}));
        repeat (2) @(negedge clk_sys);
        check(16'({ctrl_rdata, retain_ok}), 16'h0001);
        cpu_u.write_ctrl(SMC_POFF, 1'b1);
        repeat (4) @(negedge clk_sys);
        check(16'(ctrl_rdata), 16'h0000);
        cpu_u.do_sleep(0);
        check(16'(state), 16'(ST_ACTIVE));
    endtask
    task automatic t_prot();
        for (int i = 0; i < 4; i++) begin
            short_prot_cfg = i[0];
            discharge_fet_on = i[1];
            repeat (2) @(negedge clk_sys);
            check(16'(short_prot_en), 16'(i == 3));
        end
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        wake_req = 11'h000;
        discharge_fet_on = 1'b0;
        short_prot_cfg = 1'b0;
        repeat (5) @(negedge clk_sys);
        rstn = 1'b1;
        t_refused();
        t_modes();
        t_poff();
        t_prot();
        finish_test();
    end
endmodule // testbench
